// >>> rtl/ddsl_top.sv
// top of the dual converter serial load control
`include "ddsl_regs.svh"

// ************************************************************
// overview
// ************************************************************
// Functional notes
// RULE1 - serial data goes straight into the shift register
// RULE2 - each rising serial clock shifts in one data bit
// RULE3 - no shifting while select is high; host holds select low
// RULE4 - select rising moves the word to the addressed input register(s)
// RULE5 - select never gates or alters the load strobe path
// RULE6 - reset pin low forces all input and converter registers to preset
// RULE7 - midscale pin low gives an all-zero preset
// RULE8 - midscale pin high gives top data bit set, 0x8000
// RULE9 - midscale pin picks the preset on reset pulse and power-on
// RULE10 - load strobe low makes converter registers follow input registers
// RULE11 - load strobe acts on its level, not on a serial clock edge
// RULE12 - only the last 18 bits count; words arrive msb first
// RULE13 - two leading bits address: none, A, B, or both
// RULE14 - reset pin outranks a concurrent transfer or load
module ddsl_top
    import ddsl_pkg::*;
(
    input  wire logic                    mclk_i,
    input  wire logic                    nrst_i,
    input  wire logic                    serial_clk_i,
    input  wire logic                    chip_sel_n_i,
    input  wire logic                    serial_data_in_i,
    input  wire logic                    dac_load_strobe_n_i,
    input  wire logic                    dynamic_reset_n_i,
    input  wire logic                    midscale_sel_i,
    output      logic [`DDSL_DATA_W-1:0] input_a_o,
    output      logic [`DDSL_DATA_W-1:0] input_b_o,
    output      logic [`DDSL_DATA_W-1:0] dac_a_o,
    output      logic [`DDSL_DATA_W-1:0] dac_b_o,
    output      logic                    ready_o
);

    // ************************************************************
    // reset release
    // ************************************************************
    logic rst_meta_ff;
    logic rst_n_ff;

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // ************************************************************
    // pin sampling
    // ************************************************************
    ddsl_pins_t pins_raw;
    ddsl_pins_t pins_s;

    assign pins_raw.sclk   = serial_clk_i;
    assign pins_raw.cs_n   = chip_sel_n_i;
    assign pins_raw.serial_data_in    = serial_data_in_i;
    assign pins_raw.load_n = dac_load_strobe_n_i;
    assign pins_raw.rst_n  = dynamic_reset_n_i;
    assign pins_raw.mid    = midscale_sel_i;

    ddsl_sync u_sync
    (
        .clk_i   (mclk_i),
        .rst_n_i (rst_n_ff),
        .pins_i  (pins_raw),
        .pins_o  (pins_s)
    );

    // ************************************************************
    // edge detection on the synchronised pins
    // ************************************************************
    logic sclk_d_ff;
    logic cs_d_ff;
    logic nxt_sclk_d;
    logic nxt_cs_d;
    logic sclk_rise;
    logic cs_rise;
    logic cs_fall;

    always_comb
    begin
        nxt_sclk_d = pins_s.sclk;
        nxt_cs_d   = pins_s.cs_n;
    end

    always_ff @(posedge mclk_i or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            sclk_d_ff <= 1'b0;
            cs_d_ff   <= 1'b1;
        end
        else
        begin
            sclk_d_ff <= nxt_sclk_d;
            cs_d_ff   <= nxt_cs_d;
        end
    end

    assign sclk_rise = pins_s.sclk & ~sclk_d_ff;
    assign cs_rise   = pins_s.cs_n & ~cs_d_ff;
    assign cs_fall   = ~pins_s.cs_n & cs_d_ff;

    // ************************************************************
    // serial shift register
    // ************************************************************
    ddsl_word_t             sr_word;
    logic                   shift_en;
    logic [`DDSL_CNT_W-1:0] bit_count;

    // shifting only while select is held low
    assign shift_en = sclk_rise & ~pins_s.cs_n; // [RULE3] [RULE2]

    ddsl_shift u_shift
    (
        .clk_i   (mclk_i),
        .rst_n_i (rst_n_ff),
        .shift_i (shift_en),
        .start_i (cs_fall),
        .bit_i   (pins_s.serial_data_in),
        .word_o  (sr_word),
        .count_o (bit_count)
    );

    // ************************************************************
    // control state: power-up preset, then normal running
    // ************************************************************
    ddsl_state_t             state_ff;
    ddsl_state_t             nxt_state;
    logic [`DDSL_PWRUP_W-1:0] wait_ff;
    logic [`DDSL_PWRUP_W-1:0] nxt_wait;
    logic                    ready_ff;
    logic                    nxt_ready;

    // wait until the synchronised midscale pin is valid
    always_comb
    begin
        nxt_state = state_ff;
        nxt_wait  = wait_ff;
        nxt_ready = ready_ff;
        unique case (state_ff)
            DDSL_ST_PWRUP:
            begin
                if (wait_ff == `DDSL_PWRUP_CYC)
                begin
                    nxt_state = DDSL_ST_PRESET;
                end
                else
                begin
                    nxt_wait = wait_ff + 2'h1;
                end
            end
            DDSL_ST_PRESET:
            begin
                nxt_state = DDSL_ST_RUN;
                nxt_ready = 1'b1;
            end
            DDSL_ST_RUN:
            begin
                nxt_ready = 1'b1;
            end
            default:
            begin
                nxt_state = DDSL_ST_PWRUP;
                nxt_wait  = '0;
                nxt_ready = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            state_ff <= DDSL_ST_PWRUP;
            wait_ff  <= '0;
            ready_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            wait_ff  <= nxt_wait;
            ready_ff <= nxt_ready;
        end
    end

    // ************************************************************
    // preset value and transfer qualifiers
    // ************************************************************
    ddsl_code_t preset_code;
    logic       force_preset;
    logic       transfer;
    logic       load_open;
    logic       word_addr [`DDSL_NUM_CHAN];

    // zero or midscale picked by the pin
    assign preset_code  = pins_s.mid ? `DDSL_MID_CODE   // [RULE8]
                                     : `DDSL_ZERO_CODE; // [RULE7]
    // reset pin or power-up preset overrides everything
    assign force_preset = ~pins_s.rst_n                 // [RULE6] [RULE14]
                        | (state_ff == DDSL_ST_PRESET); // [RULE9]
    assign transfer     = cs_rise & (state_ff == DDSL_ST_RUN); // [RULE4]
    // strobe level and run state only, no select term and no serial clock
    assign load_open    = ~pins_s.load_n & (state_ff == DDSL_ST_RUN); // [RULE5] [RULE11]

    // address bits of the last full word: 00 none, 01 A, 10 B, 11 both
    always_comb
    begin
        unique case ({sr_word.addr_hi, sr_word.addr_lo}) // [RULE13] [RULE12]
            2'b00:
            begin
                word_addr[`DDSL_CHAN_A] = 1'b0;
                word_addr[`DDSL_CHAN_B] = 1'b0;
            end
            2'b01:
            begin
                word_addr[`DDSL_CHAN_A] = 1'b1;
                word_addr[`DDSL_CHAN_B] = 1'b0;
            end
            2'b10:
            begin
                word_addr[`DDSL_CHAN_A] = 1'b0;
                word_addr[`DDSL_CHAN_B] = 1'b1;
            end
            2'b11:
            begin
                word_addr[`DDSL_CHAN_A] = 1'b1;
                word_addr[`DDSL_CHAN_B] = 1'b1;
            end
        endcase
    end

    // ************************************************************
    // input and converter registers, one set per channel
    // ************************************************************
    ddsl_code_t inp_ff [`DDSL_NUM_CHAN];
    ddsl_code_t dac_ff [`DDSL_NUM_CHAN];

    genvar ch;
    generate
        for (ch = 0; ch < `DDSL_NUM_CHAN; ch = ch + 1)
        begin : g_chan
            ddsl_code_t nxt_inp;
            ddsl_code_t nxt_dac;

            always_comb
            begin
                nxt_inp = inp_ff[ch];
                nxt_dac = dac_ff[ch];
                if (force_preset)
                begin
                    nxt_inp = preset_code; // [RULE6] [RULE14]
                    nxt_dac = preset_code; // [RULE6]
                end
                else
                begin
                    if (transfer && word_addr[ch])
                    begin
                        nxt_inp = sr_word.data; // [RULE4] [RULE12]
                    end
                    if (load_open)
                    begin
                        nxt_dac = nxt_inp; // [RULE10]
                    end
                end
            end

            always_ff @(posedge mclk_i or negedge rst_n_ff)
            begin
                if (!rst_n_ff)
                begin
                    inp_ff[ch] <= `DDSL_ZERO_CODE;
                    dac_ff[ch] <= `DDSL_ZERO_CODE;
                end
                else
                begin
                    inp_ff[ch] <= nxt_inp;
                    dac_ff[ch] <= nxt_dac;
                end
            end
        end
    endgenerate

    // ************************************************************
    // outputs
    // ************************************************************
    assign input_a_o = inp_ff[`DDSL_CHAN_A];
    assign input_b_o = inp_ff[`DDSL_CHAN_B];
    assign dac_a_o   = dac_ff[`DDSL_CHAN_A];
    assign dac_b_o   = dac_ff[`DDSL_CHAN_B];
    assign ready_o   = ready_ff;

endmodule : ddsl_top

// >>> rtl/ddsl_regs.svh
// constants of the dual converter serial load control
`ifndef DDSL_REGS_SVH
`define DDSL_REGS_SVH

// ************************************************************
// word layout, 16-bit variant
// ************************************************************
`define DDSL_DATA_W      16
`define DDSL_ADDR_W      2
`define DDSL_WORD_W      18
`define DDSL_ADDR_HI_POS 17
`define DDSL_ADDR_LO_POS 16
`define DDSL_NUM_CHAN    2
`define DDSL_CHAN_A      0
`define DDSL_CHAN_B      1

// ************************************************************
// reset values
// ************************************************************
`define DDSL_ZERO_CODE   16'h0000
`define DDSL_MID_CODE    16'h8000

// ************************************************************
// pin sampling and power-up timing
// ************************************************************
`define DDSL_PIN_W       6
`define DDSL_PIN_SCLK    5
`define DDSL_PIN_CS      4
`define DDSL_PIN_SDI     3
`define DDSL_PIN_LOAD    2
`define DDSL_PIN_RST     1
`define DDSL_PIN_MID     0
`define DDSL_PINS_IDLE   6'h16
`define DDSL_PWRUP_W     2
`define DDSL_PWRUP_CYC   2'h3
`define DDSL_CNT_W       5
`define DDSL_CNT_MAX     5'h12

`endif

// >>> rtl/ddsl_pkg.sv
// types of the dual converter serial load control
`include "ddsl_regs.svh"

package ddsl_pkg;

    // ************************************************************
    // serial word and sampled pins
    // ************************************************************
    typedef struct packed {
        logic                       addr_hi;
        logic                       addr_lo;
        logic [`DDSL_DATA_W-1:0]    data;
    } ddsl_word_t;

    typedef struct packed {
        logic                       sclk;
        logic                       cs_n;
        logic                       serial_data_in;
        logic                       load_n;
        logic                       rst_n;
        logic                       mid;
    } ddsl_pins_t;

    typedef logic [`DDSL_DATA_W-1:0] ddsl_code_t;

    // ************************************************************
    // control states
    // ************************************************************
    typedef enum logic [1:0] {
        DDSL_ST_PWRUP  = 2'b00,
        DDSL_ST_PRESET = 2'b01,
        DDSL_ST_RUN    = 2'b10
    } ddsl_state_t;

endpackage : ddsl_pkg

// >>> rtl/ddsl_sync.sv
// two-flop synchroniser for the pin inputs
`include "ddsl_regs.svh"

module ddsl_sync
    import ddsl_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire ddsl_pins_t pins_i,
    output      ddsl_pins_t pins_o
);

    ddsl_pins_t meta_ff;
    ddsl_pins_t sync_ff;

    // ************************************************************
    // two stages; idle pattern keeps selects and resets inactive
    // ************************************************************
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_ff <= `DDSL_PINS_IDLE;
            sync_ff <= `DDSL_PINS_IDLE;
        end
        else
        begin
            meta_ff <= pins_i;
            sync_ff <= meta_ff;
        end
    end

    assign pins_o = sync_ff;

endmodule : ddsl_sync

// >>> rtl/ddsl_shift.sv
// serial shift register with bit counter
`include "ddsl_regs.svh"

module ddsl_shift
    import ddsl_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  shift_i,
    input  wire logic                  start_i,
    input  wire logic                  bit_i,
    output      ddsl_word_t            word_o,
    output      logic [`DDSL_CNT_W-1:0] count_o
);

    ddsl_word_t             sr_ff;
    ddsl_word_t             nxt_sr;
    logic [`DDSL_CNT_W-1:0] cnt_ff;
    logic [`DDSL_CNT_W-1:0] nxt_cnt;

    // ************************************************************
    // shift msb first; older bits fall off the top
    // ************************************************************
    always_comb
    begin
        nxt_sr  = sr_ff;
        nxt_cnt = cnt_ff;
        if (start_i)
        begin
            nxt_cnt = '0;
        end
        if (shift_i)
        begin
            nxt_sr = {sr_ff[`DDSL_WORD_W-2:0], bit_i}; // [RULE1] [RULE2]
            if (nxt_cnt != `DDSL_CNT_MAX)
            begin
                nxt_cnt = nxt_cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sr_ff  <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            sr_ff  <= nxt_sr;
            cnt_ff <= nxt_cnt;
        end
    end

    assign word_o  = sr_ff;
    assign count_o = cnt_ff;

endmodule : ddsl_shift

// >>> tb/ddsl_props.sv
// assertion checker of the dual converter serial load control
`include "ddsl_regs.svh"

module ddsl_props (
    input wire logic                    mclk_i,
    input wire logic                    nrst_i,
    input wire logic                    serial_clk_i,
    input wire logic                    chip_sel_n_i,
    input wire logic                    serial_data_in_i,
    input wire logic                    dac_load_strobe_n_i,
    input wire logic                    dynamic_reset_n_i,
    input wire logic                    midscale_sel_i,
    input wire logic [`DDSL_DATA_W-1:0] input_a_o,
    input wire logic [`DDSL_DATA_W-1:0] input_b_o,
    input wire logic [`DDSL_DATA_W-1:0] dac_a_o,
    input wire logic [`DDSL_DATA_W-1:0] dac_b_o,
    input wire logic                    ready_o
);
    // ********************
    // properties
    // ********************
    wire                    run = ready_o && dynamic_reset_n_i;
    wire [`DDSL_DATA_W-1:0] pre = midscale_sel_i ? 16'h8000 : 16'h0000;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    AST_RST_ZERO: assert property (
        (ready_o && !dynamic_reset_n_i && !midscale_sel_i)[*5] |->
        (input_a_o | input_b_o | dac_a_o | dac_b_o) == 16'h0000)
        else $error("reset pin left a nonzero register");
    AST_RST_MID: assert property (
        (ready_o && !dynamic_reset_n_i && midscale_sel_i)[*5] |->
        input_a_o == 16'h8000 && input_b_o == 16'h8000 &&
        dac_a_o == 16'h8000 && dac_b_o == 16'h8000)
        else $error("reset pin did not give midscale");
    AST_RST_HOLD: assert property (
        (ready_o && !dynamic_reset_n_i && $stable(midscale_sel_i))[*6] |->
        $stable(input_a_o) && $stable(input_b_o) &&
        $stable(dac_a_o) && $stable(dac_b_o))
        else $error("register moved while reset pin low");
    AST_LOAD_COPY: assert property (
        (run && !dac_load_strobe_n_i)[*6] |->
        dac_a_o == input_a_o && dac_b_o == input_b_o)
        else $error("strobe low but converter differs from input");
    AST_LOAD_NOCS: assert property (
        (run && !dac_load_strobe_n_i && !chip_sel_n_i)[*6] |->
        dac_b_o == input_b_o)
        else $error("select low blocked the strobe");
    AST_LOAD_SOON: assert property (
        run && $fell(dac_load_strobe_n_i) |-> ##[1:5] dac_a_o == input_a_o)
        else $error("strobe not acted on in time");
    AST_LOAD_HOLD: assert property (
        (run && dac_load_strobe_n_i)[*6] |->
        $stable(dac_a_o) && $stable(dac_b_o))
        else $error("converter moved with strobe high");
    AST_CS_LOW_HOLD: assert property (
        (run && !chip_sel_n_i)[*6] |->
        $stable(input_a_o) && $stable(input_b_o))
        else $error("input moved while select low");
    AST_READY_SOON: assert property (
        $rose(nrst_i) |-> ##[4:14] ready_o)
        else $error("power-up preset late");
    AST_PWRUP_PRESET: assert property (
        $rose(ready_o) |-> input_a_o == pre && dac_b_o == pre)
        else $error("power-up preset wrong");
endmodule : ddsl_props

bind ddsl_top ddsl_props ddsl_props_i (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .serial_clk_i(serial_clk_i),
    .chip_sel_n_i(chip_sel_n_i), .serial_data_in_i(serial_data_in_i),
    .dac_load_strobe_n_i(dac_load_strobe_n_i),
    .dynamic_reset_n_i(dynamic_reset_n_i), .midscale_sel_i(midscale_sel_i),
    .input_a_o(input_a_o), .input_b_o(input_b_o), .dac_a_o(dac_a_o),
    .dac_b_o(dac_b_o), .ready_o(ready_o)
);

// >>> tb/ddsl_host.sv
// host model driving the serial port, strobe and reset pins
module ddsl_host (
    input  wire logic clk_i,
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      sdi_o,
    output logic      load_n_o,
    output logic      rst_n_o,
    output logic      mid_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // ********************
    // pin drivers
    // ********************
    initial
    begin
        {sclk_o, cs_n_o, sdi_o, load_n_o, rst_n_o, mid_o} = 6'h1f;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : wait_cyc

    task automatic ctl(input logic ld_n, input logic rs_n, input logic md);
        wait_cyc(1);
        load_n_o = ld_n;
        rst_n_o  = rs_n;
        mid_o    = md;
    endtask : ctl

    // serial clock runs only inside the frame, 160 ns period
    task automatic frame(input logic [23:0] bits);
        wait_cyc(1);
        cs_n_o = 1'b0;
        for (int k = 23; k >= 0; k--)
        begin
            wait_cyc(1);
            sdi_o = bits[k];
            wait_cyc(9);
            sclk_o = 1'b1;
            wait_cyc(10);
            sclk_o = 1'b0;
        end
        wait_cyc(3);
        cs_n_o = 1'b1;
        sdi_o  = ~bits[0];
    endtask : frame
endmodule : ddsl_host

// >>> tb/tb_dual_dac_serial_load_control.sv
// self-checking bench of the dual converter serial load control
`include "ddsl_regs.svh"
`define CHK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end

module tb_dual_dac_serial_load_control
    import ddsl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ********************
    // bench
    // ********************
    logic       mclk, nrst, sclk, cs_n, serial_data_in, load_n, rst_n, mid, ready;
    ddsl_code_t in_a, in_b, dac_a, dac_b, exp_a, exp_b, exp_da, exp_db;
    ddsl_word_t w;
    logic [1:0] ad;
    logic [15:0] lfsr;
    int         n_mismatch, total_checks, i;

    initial mclk = 1'b0;
    always #4 mclk = ~mclk;

    ddsl_top ddsl_top_i (
        .mclk_i(mclk), .nrst_i(nrst), .serial_clk_i(sclk),
        .chip_sel_n_i(cs_n), .serial_data_in_i(serial_data_in),
        .dac_load_strobe_n_i(load_n), .dynamic_reset_n_i(rst_n),
        .midscale_sel_i(mid), .input_a_o(in_a), .input_b_o(in_b),
        .dac_a_o(dac_a), .dac_b_o(dac_b), .ready_o(ready)
    );
    ddsl_host ddsl_host_i (
        .clk_i(mclk), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(serial_data_in),
        .load_n_o(load_n), .rst_n_o(rst_n), .mid_o(mid)
    );

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    function automatic ddsl_code_t preset_of(input logic m);
        return m ? `DDSL_MID_CODE : `DDSL_ZERO_CODE;
    endfunction : preset_of

    task automatic check_all();
        `CHK(in_a, exp_a)
        `CHK(in_b, exp_b)
        `CHK(dac_a, exp_da)
        `CHK(dac_b, exp_db)
    endtask : check_all

    task automatic set_all(input ddsl_code_t v);
        {exp_a, exp_b, exp_da, exp_db} = {v, v, v, v};
    endtask : set_all

    // random leading bits must be dropped
    task automatic send(input ddsl_word_t wd, input logic ld_low);
        lfsr = lfsr_next(lfsr);
        ddsl_host_i.frame({lfsr[5:0], wd});
        if (wd.addr_lo) exp_a = wd.data;
        if (wd.addr_hi) exp_b = wd.data;
        if (ld_low) {exp_da, exp_db} = {exp_a, exp_b};
        repeat (8) @(posedge mclk);
        check_all();
    endtask : send

    task automatic pulse_load(input logic rs_n);
        ddsl_host_i.ctl(1'b0, rs_n, mid);
        repeat (6) @(posedge mclk);
        ddsl_host_i.ctl(1'b1, rs_n, mid);
        if (rs_n) {exp_da, exp_db} = {exp_a, exp_b};
        repeat (6) @(posedge mclk);
        check_all();
    endtask : pulse_load

    task automatic final_report();
        if (n_mismatch == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report

    initial
    begin
        repeat (30000) @(posedge mclk);
        n_mismatch++;
        final_report();
    end

    initial
    begin
        nrst = 1'b0;
        lfsr = 16'h0057;
        n_mismatch = 0;
        total_checks = 0;
        set_all(`DDSL_MID_CODE);
        repeat (12) @(posedge mclk);
        #1 nrst = 1'b1;
        for (i = 0; i < 50 && ready !== 1'b1; i++) @(posedge mclk);
        repeat (6) @(posedge mclk);
        `CHK(ready, 1'b1)
        check_all();
        for (i = 0; i < 16; i++)
        begin
            lfsr = lfsr_next(lfsr);
            ad = (i < 4) ? i[1:0] : lfsr[1:0];
            lfsr = lfsr_next(lfsr);
            w = {ad, lfsr};
            if (i % 4 == 3) ddsl_host_i.ctl(1'b0, 1'b1, 1'b1);
            send(w, i % 4 == 3);
            if (i % 4 == 3) ddsl_host_i.ctl(1'b1, 1'b1, 1'b1);
            else if (i % 3 == 1) pulse_load(1'b1);
        end
        for (i = 0; i < 2; i++)
        begin
            ddsl_host_i.ctl(1'b1, 1'b0, i[0]);
            repeat (6) @(posedge mclk);
            set_all(preset_of(i[0]));
            check_all();
            ddsl_host_i.frame(24'hff5a5a);
            repeat (8) @(posedge mclk);
            pulse_load(1'b0);
            ddsl_host_i.ctl(1'b1, 1'b1, i[0]);
            repeat (6) @(posedge mclk);
            check_all();
        end
        send({2'b11, 16'h1234}, 1'b0);
        final_report();
    end
endmodule : tb_dual_dac_serial_load_control
